//--- logic/ccmc_pkg.sv
package ccmc_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DUTY_HIGH = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_COMPARE = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 5'h10;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam int STAT_CNT_LSB = 4;
    localparam int CFG_TSEL_BIT = 0;
    localparam logic [5:0] CONTROL_RST = 6'h00;
    localparam logic [7:0] DUTY_HIGH_RST = 8'h00;
    localparam logic [15:0] COMPARE_RST = 16'h0000;
    localparam int PRESC_W = 4;

    // ************************************************************
    // Mode codes
    // ************************************************************
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_RSVD1 = 4'h1;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_RSVD3 = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET_HI = 4'h8;
    localparam logic [3:0] MODE_CMP_SET_LO = 4'h9;
    localparam logic [3:0] MODE_CMP_SWIRQ = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    localparam logic [PRESC_W-1:0] PRESC_LAST4 = 4'h3;
    localparam logic [PRESC_W-1:0] PRESC_LAST16 = 4'hF;

    // ************************************************************
    // AXI response codes
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register fields
    typedef struct packed {
        logic [1:0] duty_low_bits;
        logic [3:0] module_mode_select;
    } ccmc_ctrl_t;

    // Pulses sent to the timers and converter
    typedef struct packed {
        logic timer_one_reset;
        logic timer_three_reset;
        logic adc_start;
    } ccmc_trig_t;

endpackage

//--- logic/ccmc_capture_presc.sv
`timescale 1ns/1ps
module ccmc_capture_presc (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pin and mode
    input wire logic pin_level,
    input wire logic [3:0] mode,
    // Results
    output logic capture_pulse,
    output logic [ccmc_pkg::PRESC_W-1:0] presc_count
);
    import ccmc_pkg::*;

    logic pin_r;
    logic pulse_r;
    logic pulse_nxt;
    logic [PRESC_W-1:0] cnt_r;
    logic [PRESC_W-1:0] cnt_nxt;

    // Edge detection on the sampled pin
    wire rise = pin_level & ~pin_r;
    wire fall = ~pin_level & pin_r;
    wire is_capture = (mode[3:2] == 2'b01);

    // Counter is held clear outside capture; a direct switch between
    // prescaler settings keeps the count, so a count at or past the
    // new limit fires on the next rising edge
    always_comb begin
        cnt_nxt = cnt_r;
        pulse_nxt = 1'b0;
        if (!is_capture) begin
            cnt_nxt = '0;
        end else begin
            unique case (mode)
                MODE_CAP_FALL: pulse_nxt = fall;
                MODE_CAP_RISE: pulse_nxt = rise;
                MODE_CAP_RISE4: begin
                    if (rise && cnt_r >= PRESC_LAST4) begin
                        pulse_nxt = 1'b1;
                        cnt_nxt = '0;
                    end else if (rise) begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                MODE_CAP_RISE16: begin
                    if (rise && cnt_r == PRESC_LAST16) begin
                        pulse_nxt = 1'b1;
                        cnt_nxt = '0;
                    end else if (rise) begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                default: pulse_nxt = 1'b0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_r <= 1'b0;
            cnt_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            pin_r <= pin_level;
            cnt_r <= cnt_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign capture_pulse = pulse_r;
    assign presc_count = cnt_r;

endmodule

//--- logic/ccmc_top.sv
`timescale 1ns/1ps
module ccmc_top #(
    parameter int MODULE_INDEX = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write channels
    input wire logic [ccmc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [ccmc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Module pin and time bases
    input wire logic module_pin_in,
    input wire logic [15:0] timer_one_pair,
    input wire logic [15:0] timer_three_pair,
    // Pin drive and events
    output logic compare_out,
    output logic compare_drive_en,
    output logic module_event_flag,
    output ccmc_pkg::ccmc_trig_t trig,
    // PWM duty for the waveform generator
    output logic [9:0] duty_value,
    output logic pwm_mode
);
    import ccmc_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    ccmc_ctrl_t ctrl_r;
    logic [7:0] duty_high_r;
    logic [15:0] cmp_r;
    logic tsel_r;
    logic flag_r;
    logic latch_r;
    logic eq_r;
    ccmc_trig_t trig_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic capture_pulse;
    logic [PRESC_W-1:0] presc_count;

    // ************************************************************
    // Mode decode
    // ************************************************************
    wire [3:0] mode = ctrl_r.module_mode_select;
    wire is_cap = (mode[3:2] == 2'b01);
    wire is_pwm = (mode[3:2] == 2'b11);
    wire is_cmp = (mode == MODE_CMP_TOGGLE) || (mode[3:2] == 2'b10);
    wire trig_mode = (mode == MODE_CMP_TRIG) && (MODULE_INDEX != 3);

    // Compare runs continuously; only the rising of equality counts,
    // so a stopped timer sitting on the value fires just once
    wire [15:0] timer_sel = tsel_r ? timer_three_pair : timer_one_pair;
    wire eq_now = is_cmp && (timer_sel == cmp_r);
    wire match = eq_now && !eq_r;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire wr_ctrl = wr_fire && (awaddr_r == OFS_CONTROL) && wstrb_r[0];
    wire wr_duty = wr_fire && (awaddr_r == OFS_DUTY_HIGH) && wstrb_r[0];
    wire wr_cmp_lo = wr_fire && (awaddr_r == OFS_COMPARE) && wstrb_r[0];
    wire wr_cmp_hi = wr_fire && (awaddr_r == OFS_COMPARE) && wstrb_r[1];
    wire wr_stat = wr_fire && (awaddr_r == OFS_STATUS) && wstrb_r[0];
    wire wr_cfg = wr_fire && (awaddr_r == OFS_CONFIG) && wstrb_r[0];
    wire wr_mapped = (awaddr_r == OFS_CONTROL) ||
        (awaddr_r == OFS_DUTY_HIGH) || (awaddr_r == OFS_COMPARE) ||
        (awaddr_r == OFS_STATUS) || (awaddr_r == OFS_CONFIG);
    wire ccmc_ctrl_t new_ctrl = wdata_r[5:0];
    wire new_mode_diff = new_ctrl.module_mode_select != mode;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;

    // ************************************************************
    // Read mux
    // ************************************************************
    wire [31:0] stat_word = {24'h000000, presc_count, 2'b00,
        latch_r, flag_r};
    wire rd_mapped = (s_axi_araddr == OFS_CONTROL) ||
        (s_axi_araddr == OFS_DUTY_HIGH) || (s_axi_araddr == OFS_COMPARE) ||
        (s_axi_araddr == OFS_STATUS) || (s_axi_araddr == OFS_CONFIG);
    wire [31:0] rd_word =
        (s_axi_araddr == OFS_CONTROL) ? {26'h0000000, ctrl_r} :
        (s_axi_araddr == OFS_DUTY_HIGH) ? {24'h000000, duty_high_r} :
        (s_axi_araddr == OFS_COMPARE) ? {16'h0000, cmp_r} :
        (s_axi_araddr == OFS_STATUS) ? stat_word :
        (s_axi_araddr == OFS_CONFIG) ? {31'h00000000, tsel_r} :
        32'h00000000;

    // ************************************************************
    // Next values of the block state
    // ************************************************************
    // Flag: hardware set wins over a same-cycle write-one clear
    wire evt_set = (match && (mode != MODE_RSVD1)) ||
        (is_cap && capture_pulse);
    wire flag_nxt = evt_set ||
        (flag_r && !(wr_stat && wdata_r[STAT_FLAG_BIT]));

    // Pin latch: cleared by OFF, preset on entry to a forced-level mode, changed on match
    logic latch_nxt;
    always_comb begin
        latch_nxt = latch_r;
        if (wr_ctrl && new_ctrl.module_mode_select == MODE_OFF) begin
            latch_nxt = 1'b0;
        end else if (wr_ctrl && new_mode_diff &&
            new_ctrl.module_mode_select == MODE_CMP_SET_LO) begin
            latch_nxt = 1'b1;
        end else if (wr_ctrl && new_mode_diff &&
            new_ctrl.module_mode_select == MODE_CMP_SET_HI) begin
            latch_nxt = 1'b0;
        end else if (match && mode == MODE_CMP_TOGGLE) begin
            latch_nxt = !latch_r;
        end else if (match && mode == MODE_CMP_SET_LO) begin
            latch_nxt = 1'b0;
        end else if (match && mode == MODE_CMP_SET_HI) begin
            latch_nxt = 1'b1;
        end
    end

    // Capture overrides a same-cycle software write of the value
    logic [15:0] cmp_nxt;
    always_comb begin
        cmp_nxt = cmp_r;
        if (wr_cmp_lo) begin
            cmp_nxt[7:0] = wdata_r[7:0];
        end
        if (wr_cmp_hi) begin
            cmp_nxt[15:8] = wdata_r[15:8];
        end
        if (is_cap && capture_pulse) begin
            cmp_nxt = timer_sel;
        end
    end

    // Trigger resets the assigned pair; only module two converts
    ccmc_trig_t trig_nxt;
    always_comb begin
        trig_nxt.timer_one_reset = match && trig_mode && !tsel_r;
        trig_nxt.timer_three_reset = match && trig_mode && tsel_r;
        trig_nxt.adc_start = match && trig_mode &&
            (MODULE_INDEX == 2);
    end

    // ************************************************************
    // Block state registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r <= CONTROL_RST;
            duty_high_r <= DUTY_HIGH_RST;
            cmp_r <= COMPARE_RST;
            tsel_r <= 1'b0;
            flag_r <= 1'b0;
            latch_r <= 1'b0;
            eq_r <= 1'b0;
            trig_r <= '0;
        end else begin
            ctrl_r <= wr_ctrl ? new_ctrl : ctrl_r;
            duty_high_r <= wr_duty ? wdata_r[7:0] : duty_high_r;
            cmp_r <= cmp_nxt;
            tsel_r <= wr_cfg ? wdata_r[CFG_TSEL_BIT] : tsel_r;
            flag_r <= flag_nxt;
            latch_r <= latch_nxt;
            eq_r <= eq_now;
            trig_r <= trig_nxt;
        end
    end

    // ************************************************************
    // AXI4-Lite channel registers
    // ************************************************************
    // Address and data are held separately so either may come first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awaddr_r <= '0;
            aw_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            w_held_r <= 1'b0;
        end else begin
            awaddr_r <= aw_take ? s_axi_awaddr : awaddr_r;
            wdata_r <= w_take ? s_axi_wdata : wdata_r;
            wstrb_r <= w_take ? s_axi_wstrb : wstrb_r;
            aw_held_r <= aw_take || (aw_held_r && !wr_fire);
            w_held_r <= w_take || (w_held_r && !wr_fire);
        end
    end

    // Write response and read data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else begin
            bvalid_r <= wr_fire || (bvalid_r && !s_axi_bready);
            bresp_r <= wr_fire ? (wr_mapped ? RESP_OKAY : RESP_SLVERR) :
                bresp_r;
            rvalid_r <= ar_take || (rvalid_r && !s_axi_rready);
            rdata_r <= ar_take ? rd_word : rdata_r;
            rresp_r <= ar_take ? (rd_mapped ? RESP_OKAY : RESP_SLVERR) :
                rresp_r;
        end
    end

    // ************************************************************
    // Capture prescaler
    // ************************************************************
    ccmc_capture_presc u_presc (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_level(module_pin_in),
        .mode(mode),
        .capture_pulse(capture_pulse),
        .presc_count(presc_count)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign compare_out = latch_r;
    // Port keeps its own data when not in a driving compare mode
    assign compare_drive_en = (mode == MODE_CMP_TOGGLE) ||
        (mode == MODE_CMP_SET_HI) || (mode == MODE_CMP_SET_LO);
    assign module_event_flag = flag_r;
    assign trig = trig_r;
    assign duty_value = {duty_high_r, ctrl_r.duty_low_bits};
    assign pwm_mode = is_pwm;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic rd_ctrl_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ctrl_r <= 1'b0;
        end else if (ar_take) begin
            rd_ctrl_r <= (s_axi_araddr == OFS_CONTROL);
        end
    end

    a_ctrl_top_zero: assert property (
        (s_axi_rvalid && rd_ctrl_r) |-> (s_axi_rdata[31:6] == 26'h0))
        else $error("control read shows upper bits set");

    a_off_latch_low: assert property (
        (mode == MODE_OFF) |-> (!compare_out && !compare_drive_en))
        else $error("latch not low while module off");

    a_toggle_match: assert property (
        (match && mode == MODE_CMP_TOGGLE && !wr_ctrl) |=>
        (compare_out == !$past(compare_out)) && module_event_flag)
        else $error("toggle compare did not act");

    a_force_low: assert property (
        (match && mode == MODE_CMP_SET_LO && !wr_ctrl) |=>
        (!compare_out && module_event_flag))
        else $error("match did not force pin low");

    a_force_high: assert property (
        (match && mode == MODE_CMP_SET_HI && !wr_ctrl) |=>
        (compare_out && module_event_flag))
        else $error("match did not force pin high");

    a_sw_irq_pin: assert property (
        (mode == MODE_CMP_SWIRQ) |-> !compare_drive_en)
        else $error("software interrupt mode drives pin");

    a_trig_reset: assert property (
        (match && trig_mode) |=>
        (trig.timer_one_reset != trig.timer_three_reset) ##1
        (trig == '0 || $past(match)))
        else $error("trigger pulse missing or stuck");

    a_no_adc_first: assert property (
        trig.adc_start |->
        (MODULE_INDEX == 2) && $past(match) && $past(trig_mode))
        else $error("conversion started by wrong module");

    a_presc_clear: assert property (
        !is_cap |=> (presc_count == '0) || is_cap)
        else $error("prescaler not cleared outside capture");

    a_capture_load: assert property (
        (is_cap && capture_pulse) |=>
        (cmp_r == $past(timer_sel)) && module_event_flag)
        else $error("capture did not load timer value");

    a_reserved_quiet: assert property (
        (mode == MODE_RSVD1 || mode == MODE_RSVD3) |=>
        (trig == '0) && !compare_drive_en && $stable(compare_out)
        || $past(wr_ctrl))
        else $error("reserved mode caused activity");

    c_toggle: cover property (match && mode == MODE_CMP_TOGGLE);
    c_capture: cover property (is_cap && capture_pulse);
    c_trigger: cover property (trig.timer_one_reset || trig.adc_start);
    c_flag_clear: cover property (flag_r ##1 !flag_r);

endmodule

//--- sim/ccmc_tb.sv
`timescale 1ns/1ps
module testbench;
    import ccmc_pkg::*;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [ADDR_W-1:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, pin = 1'h0, trig_clr = 1'h0;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] t1 = 16'h0, t3 = 16'h0;
    logic cmp_out, drv_en, flag, pwm, flag3;
    logic [9:0] duty;
    ccmc_trig_t trig, trig_seen, trig1, trig_seen1, trig3, trig_seen3;
    logic [3:0] md [7] = '{4'h1, 4'h3, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
    // Entry latch, latch after match, drive enable, flag
    logic [3:0] ex [7] = '{4'h0, 4'h0, 4'h7, 4'h7, 4'hB, 4'h1, 4'h1};
    int n_mismatch = 0;
    int comparisons = 0;

    ccmc_top dut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .module_pin_in(pin),
        .timer_one_pair(t1), .timer_three_pair(t3), .compare_out(cmp_out),
        .compare_drive_en(drv_en), .module_event_flag(flag), .trig(trig),
        .duty_value(duty), .pwm_mode(pwm));

    // Sibling modules share the bus and react in step with dut; only
    // their triggers and the flag of dut_three are watched, so bus outputs stay open
    ccmc_top #(.MODULE_INDEX(1)) dut_one (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
        .module_pin_in(pin), .timer_one_pair(t1), .timer_three_pair(t3),
        .compare_out(), .compare_drive_en(), .module_event_flag(),
        .trig(trig1), .duty_value(), .pwm_mode());
    ccmc_top #(.MODULE_INDEX(3)) dut_three (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
        .module_pin_in(pin), .timer_one_pair(t1), .timer_three_pair(t3),
        .compare_out(), .compare_drive_en(), .module_event_flag(flag3),
        .trig(trig3), .duty_value(), .pwm_mode());

    // Clock; trigger pulses last one cycle, so they are gathered
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        trig_seen <= trig_clr ? 3'h0 : (trig_seen | trig);
        trig_seen1 <= trig_clr ? 3'h0 : (trig_seen1 | trig1);
        trig_seen3 <= trig_clr ? 3'h0 : (trig_seen3 | trig3);
    end

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Readies sampled mid-cycle, valid dropped by the taking edge
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ha, hw, da, dw, hb;
        da = 1'h0;
        dw = 1'h0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge clk_sys);
            ha = awvalid && awready && !da;
            hw = wvalid && wready && !dw;
            @(posedge clk_sys);
            if (ha) awvalid <= 1'h0;
            if (hw) wvalid <= 1'h0;
            da = da | ha;
            dw = dw | hw;
        end while (!(da && dw));
        do begin
            @(negedge clk_sys);
            hb = bvalid;
            resp = bresp;
            @(posedge clk_sys);
        end while (!hb);
        bready <= 1'h0;
    endtask

    task automatic rdr(input logic [4:0] a);
        logic h;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge clk_sys);
            h = arready;
            @(posedge clk_sys);
        end while (!h);
        arvalid <= 1'h0;
        do begin
            @(negedge clk_sys);
            h = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge clk_sys);
        end while (!h);
        rready <= 1'h0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Timers move only on the clock, as a synchronous time base must
    task automatic set_tm(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_sys);
        t1 <= a;
        t3 <= b;
        trig_clr <= 1'h1;
        @(posedge clk_sys);
        trig_clr <= 1'h0;
        tick(4);
    endtask

    task automatic rises(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            pin <= 1'h1;
            tick(3);
            @(posedge clk_sys);
            pin <= 1'h0;
            tick(3);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d compared, %0d failed", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        rdr(OFS_CONTROL);
        chk(rd, 32'h0);
        wr(OFS_CONTROL, 32'hFF);
        wr(OFS_DUTY_HIGH, 32'hA5);
        rdr(OFS_CONTROL);
        chk(rd, 32'h3F);
        chk(duty, 10'h297);
        chk(pwm, 1'h1);
        rdr(5'h14);
        chk(rd, 32'h0);
        chk(resp, RESP_SLVERR);
        wr(5'h14, 32'h1);
        chk(resp, RESP_SLVERR);
        $display("Test registers done");
        // Compare modes, reserved codes first
        for (int i = 0; i < 7; i++) begin
            wr(OFS_CONTROL, 32'h0);
            set_tm(16'h0, 16'h0);
            chk(cmp_out, 1'h0);
            wr(OFS_COMPARE, 32'h40);
            wr(OFS_CONTROL, {28'h0, md[i]});
            wr(OFS_STATUS, 32'h1);
            tick(1);
            chk(cmp_out, ex[i][3]);
            chk(drv_en, ex[i][1]);
            set_tm(16'h40, 16'h0);
            chk(cmp_out, ex[i][2]);
            chk(flag, ex[i][0]);
            chk(trig_seen, (md[i] == 4'hB) ? 3'h5 : 3'h0);
            chk(trig_seen1, (md[i] == 4'hB) ? 3'h4 : 3'h0);
            chk({trig_seen3, flag3}, {3'h0, ex[i][0]});
        end
        // Trigger follows the assigned time base
        wr(OFS_CONFIG, 32'h1);
        set_tm(16'h40, 16'h0);
        chk(trig_seen, 3'h0);
        set_tm(16'h40, 16'h40);
        chk(trig_seen, 3'h3);
        chk(trig_seen1, 3'h2);
        wr(OFS_CONFIG, 32'h0);
        $display("Test compare done");
        // Capture on rising then falling edges
        wr(OFS_CONTROL, 32'h0);
        set_tm(16'h1234, 16'h0);
        wr(OFS_CONTROL, 32'h5);
        wr(OFS_STATUS, 32'h1);
        rises(1);
        rdr(OFS_COMPARE);
        chk(rd, 32'h1234);
        wr(OFS_CONTROL, 32'h4);
        set_tm(16'h2345, 16'h0);
        @(posedge clk_sys);
        pin <= 1'h1;
        tick(4);
        rdr(OFS_COMPARE);
        chk(rd, 32'h1234);
        @(posedge clk_sys);
        pin <= 1'h0;
        tick(4);
        rdr(OFS_COMPARE);
        chk(rd, 32'h2345);
        // Prescalers, direct switch keeps the count
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, 32'h6);
        wr(OFS_STATUS, 32'h1);
        rises(2);
        wr(OFS_CONTROL, 32'h7);
        rdr(OFS_STATUS);
        chk(rd[7:4], 4'h2);
        wr(OFS_CONTROL, 32'h0);
        rdr(OFS_STATUS);
        chk(rd[7:4], 4'h0);
        wr(OFS_CONTROL, 32'h6);
        rises(3);
        chk(flag, 1'h0);
        rises(1);
        chk(flag, 1'h1);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, 32'h7);
        wr(OFS_STATUS, 32'h1);
        rises(15);
        chk(flag, 1'h0);
        rises(1);
        chk(flag, 1'h1);
        wr(OFS_CONTROL, 32'h2);
        rdr(OFS_STATUS);
        chk(rd[7:4], 4'h0);
        $display("Test capture done");
        finish_test();
    end
endmodule
